// [verilog/erlf_consts.vh]
/*
 embedded line framer constants: tag codes, row start addresses, encodings.
 assumes a verilog-2005 compiler; included by bare name.
*/
`ifndef ERLF_CONSTS_VH
`define ERLF_CONSTS_VH
`define ERLF_TAG_FORMAT     8'h0a
`define ERLF_TAG_IDX_HI     8'haa
`define ERLF_TAG_IDX_LO     8'ha5
`define ERLF_TAG_AUTOINC    8'h5a
`define ERLF_NULL_CODE      8'h07
`define ERLF_RAW10_LSBS     2'h1
`define ERLF_ROW0_ADDR      16'h0000
`define ERLF_ROW1_ADDR      16'h0200
`define ERLF_PAR_SRC_FIFO   3'h2
`define ERLF_PEDESTAL_LO    8'h2a
`define ERLF_SCALE_N_LO     8'h10
`define ERLF_GAIN_MAX_LO    8'h7f
`define ERLF_FIFO_DEPTH     4
`define ERLF_LINE_WORDS     12'd256
`endif

// [verilog/erlf_fifo.v]
/*
 small synchronous fifo with valid/ready on both sides.
 assumes a single clock and synchronous active-low reset.
*/
`timescale 1ns/100ps
module erlf_fifo #(
    parameter WIDTH = 10,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             i_ref_clk,
    input  wire             i_nrst,
    input  wire [WIDTH-1:0] i_data,
    input  wire             i_valid,
    output wire             o_ready,
    output wire [WIDTH-1:0] o_data,
    output wire             o_valid,
    input  wire             i_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wp_r;
    reg [AW-1:0]    rp_r;
    reg [AW:0]      cnt_r;
    wire            wr;
    wire            rd;
    assign o_ready = (cnt_r != DEPTH[AW:0]);
    assign o_valid = (cnt_r != {(AW+1){1'b0}});
    assign o_data  = mem[rp_r];
    assign wr      = i_valid & o_ready;
    assign rd      = o_valid & i_ready;
    always @(posedge i_ref_clk) begin
        if (wr) begin
            mem[wp_r] <= i_data;
        end
        if (!i_nrst) begin
            wp_r  <= {AW{1'b0}};
            rp_r  <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end else begin
            if (wr) begin
                wp_r <= (wp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
            end
            if (rd) begin
                rp_r <= (rp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
            end
            if (wr && !rd) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (rd && !wr) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule

// [verilog/erlf_framer.v]
/*
 embedded register line framer: builds the two tagged register lines that
 precede the image. register bytes are fetched from a register file outside
 by address with one cycle read latency; a short entry table tells which
 address runs are embedded. assumes i_frame_start is a one-cycle pulse on
 i_ref_clk from logic on the same clock, and the register port returns the
 live value used for the current frame.
 a byte met by a full fifo is parked, so no register is read twice.
*/
`timescale 1ns/100ps
`include "erlf_consts.vh"
module erlf_framer #(
    parameter LINE_WORDS = 256
) (
    input  wire        i_ref_clk,
    input  wire        i_nrst,
    input  wire        i_frame_start,
    input  wire        i_serial_path,
    input  wire [2:0]  i_parallel_output_source_select,
    input  wire        i_raw10,
    input  wire [7:0]  i_reg_data,
    input  wire        i_out_ready,
    output reg  [15:0] o_reg_addr,
    output reg         o_reg_rd,
    output reg  [9:0]  o_data,
    output reg         o_valid,
    output reg         o_line_start,
    output reg         o_line_end,
    output reg         o_busy
);
    // ------------------------------------------------------------
    // run table: start address and byte count of each embedded run
    // ------------------------------------------------------------
    localparam NRUN = 24;
    function [23:0] run_entry;
        input [4:0] idx;
        begin
            case (idx)
                5'd0:  run_entry = {16'h0000, 8'd10};
                5'd1:  run_entry = {16'h0010, 8'd16};
                5'd2:  run_entry = {16'h0040, 8'd32};
                5'd3:  run_entry = {16'h0080, 8'd2};
                5'd4:  run_entry = {16'h0084, 8'd16};
                5'd5:  run_entry = {16'h00c0, 8'd16};
                5'd6:  run_entry = {16'h0100, 8'd6};
                5'd7:  run_entry = {16'h0110, 8'd4};
                5'd8:  run_entry = {16'h0120, 8'd2};
                5'd9:  run_entry = {16'h0200, 8'd22};
                5'd10: run_entry = {16'h0300, 8'd12};
                5'd11: run_entry = {16'h0340, 8'd16};
                5'd12: run_entry = {16'h0380, 8'd8};
                5'd13: run_entry = {16'h0400, 8'd8};
                5'd14: run_entry = {16'h0500, 8'd2};
                5'd15: run_entry = {16'h0600, 8'd18};
                default: run_entry = 24'h000000;
            endcase
        end
    endfunction
    // row 0 uses runs 0..8, row 1 uses runs 9..15
    localparam [4:0] ROW0_FIRST = 5'd0;
    localparam [4:0] ROW0_LAST  = 5'd8;
    localparam [4:0] ROW1_FIRST = 5'd9;
    localparam [4:0] ROW1_LAST  = 5'd15;

    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    localparam [3:0] S_IDLE  = 4'd0;
    localparam [3:0] S_FMT   = 4'd1;
    localparam [3:0] S_IHI   = 4'd2;
    localparam [3:0] S_AHI   = 4'd3;
    localparam [3:0] S_ILO   = 4'd4;
    localparam [3:0] S_ALO   = 4'd5;
    localparam [3:0] S_TAG   = 4'd6;
    localparam [3:0] S_FETCH = 4'd7;
    localparam [3:0] S_DATA  = 4'd8;
    localparam [3:0] S_NULL  = 4'd9;

    // ------------------------------------------------------------
    // byte to word encoding
    // ------------------------------------------------------------
    function [9:0] enc;
        input [7:0] b;
        input       r10;
        begin
            if (r10) begin
                enc = {b, `ERLF_RAW10_LSBS};
            end else begin
                enc = {2'h0, b};
            end
        end
    endfunction

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    reg [3:0]  st_r;
    reg        row_r;
    reg [4:0]  run_r;
    reg [7:0]  left_r;
    reg [15:0] addr_r;
    reg [11:0] wcnt_r;
    reg        r10_r;
    reg [7:0]  hold_r;
    reg        hold_v_r;

    reg [7:0]  byte_w;
    reg        push_w;
    wire       f_ready;
    wire [9:0] f_data;
    wire       f_valid;
    wire [23:0] ent;
    wire [23:0] nxt_ent;
    wire [7:0]  rdata_w;
    wire        enabled;

    assign ent     = run_entry(run_r);
    assign nxt_ent = run_entry(run_r + 5'd1);
    assign rdata_w = hold_v_r ? hold_r : i_reg_data;
    assign enabled = i_serial_path |
                     (i_parallel_output_source_select == `ERLF_PAR_SRC_FIFO);

    // ------------------------------------------------------------
    // word byte per state
    // ------------------------------------------------------------
    always @* begin
        byte_w = `ERLF_NULL_CODE;
        push_w = 1'b0;
        case (st_r)
            S_FMT:  begin byte_w = `ERLF_TAG_FORMAT;  push_w = 1'b1; end
            S_IHI:  begin byte_w = `ERLF_TAG_IDX_HI;  push_w = 1'b1; end
            S_AHI:  begin byte_w = addr_r[15:8];      push_w = 1'b1; end
            S_ILO:  begin byte_w = `ERLF_TAG_IDX_LO;  push_w = 1'b1; end
            S_ALO:  begin byte_w = addr_r[7:0];       push_w = 1'b1; end
            S_TAG:  begin byte_w = `ERLF_TAG_AUTOINC; push_w = 1'b1; end
            S_DATA: begin byte_w = rdata_w;           push_w = 1'b1; end
            S_NULL: begin byte_w = `ERLF_NULL_CODE;   push_w = 1'b1; end
            default: begin byte_w = `ERLF_NULL_CODE;  push_w = 1'b0; end
        endcase
    end

    // ------------------------------------------------------------
    // sequencer; stalls while the fifo is full
    // ------------------------------------------------------------
    always @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            st_r       <= S_IDLE;
            row_r      <= 1'b0;
            run_r      <= 5'd0;
            left_r     <= 8'h00;
            addr_r     <= 16'h0000;
            wcnt_r     <= 12'h000;
            r10_r      <= 1'b0;
            o_reg_addr <= 16'h0000;
            o_reg_rd   <= 1'b0;
            o_busy     <= 1'b0;
        end else begin
            o_reg_rd <= 1'b0;
            if (st_r == S_IDLE) begin
                if (i_frame_start && enabled) begin
                    st_r   <= S_FMT;
                    row_r  <= 1'b0;
                    run_r  <= ROW0_FIRST;
                    r10_r  <= i_raw10;
                    wcnt_r <= 12'h000;
                    o_busy <= 1'b1;
                end
            end else if (st_r == S_FETCH) begin
                st_r <= S_DATA;
            end else if (f_ready) begin
                wcnt_r <= wcnt_r + 1'b1;
                case (st_r)
                    S_FMT: begin
                        st_r   <= S_IHI;
                        addr_r <= ent[23:8];
                        left_r <= ent[7:0];
                    end
                    S_IHI: st_r <= S_AHI;
                    S_AHI: st_r <= S_ILO;
                    S_ILO: st_r <= S_ALO;
                    S_ALO: st_r <= S_TAG;
                    S_TAG: begin
                        st_r       <= S_FETCH;
                        o_reg_addr <= addr_r;
                        o_reg_rd   <= 1'b1;
                    end
                    S_DATA: begin
                        addr_r <= addr_r + 16'h0001;
                        left_r <= left_r - 8'h01;
                        if (left_r != 8'h01) begin
                            st_r <= S_TAG;
                        end else if (run_r == (row_r ? ROW1_LAST : ROW0_LAST)) begin
                            st_r <= S_NULL;
                        end else begin
                            run_r  <= run_r + 5'd1;
                            addr_r <= nxt_ent[23:8];
                            left_r <= nxt_ent[7:0];
                            st_r   <= S_IHI;
                        end
                    end
                    S_NULL: begin
                        if (wcnt_r == LINE_WORDS[11:0] - 12'd1) begin
                            wcnt_r <= 12'h000;
                            if (!row_r) begin
                                row_r <= 1'b1;
                                run_r <= ROW1_FIRST;
                                st_r  <= S_FMT;
                            end else begin
                                st_r   <= S_IDLE;
                                o_busy <= 1'b0;
                            end
                        end
                    end
                    default: st_r <= S_IDLE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // read data hold: the register port shows a byte for one cycle
    // only, so a byte caught by a full fifo is parked here
    // ------------------------------------------------------------
    always @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            hold_r   <= 8'h00;
            hold_v_r <= 1'b0;
        end else if (st_r != S_DATA || f_ready) begin
            hold_v_r <= 1'b0;
        end else if (!hold_v_r) begin
            hold_r   <= i_reg_data;
            hold_v_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // push path into the fifo
    // ------------------------------------------------------------
    wire [9:0] push_data;
    assign push_data = enc(byte_w, r10_r);
    wire push_go;
    assign push_go = push_w & (st_r != S_IDLE) & (st_r != S_FETCH);

    // ------------------------------------------------------------
    // output buffer
    // ------------------------------------------------------------
    erlf_fifo #(
        .WIDTH (10),
        .DEPTH (`ERLF_FIFO_DEPTH),
        .AW    (2)
    ) u_fifo (
        .i_ref_clk (i_ref_clk),
        .i_nrst    (i_nrst),
        .i_data    (push_data),
        .i_valid   (push_go),
        .o_ready   (f_ready),
        .o_data    (f_data),
        .o_valid   (f_valid),
        .i_ready   (i_out_ready | ~o_valid)
    );

    // ------------------------------------------------------------
    // output register: a word stands until i_out_ready takes it;
    // line markers count words leaving, so a stall cannot skew them
    // ------------------------------------------------------------
    reg [11:0] ocnt_r;
    always @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            o_data       <= 10'h000;
            o_valid      <= 1'b0;
            o_line_start <= 1'b0;
            o_line_end   <= 1'b0;
            ocnt_r       <= 12'h000;
        end else if (i_out_ready | ~o_valid) begin
            o_valid      <= f_valid;
            o_data       <= f_data;
            o_line_start <= f_valid & (ocnt_r == 12'h000);
            o_line_end   <= f_valid & (ocnt_r == LINE_WORDS[11:0] - 12'd1);
            if (f_valid) begin
                ocnt_r <= (ocnt_r == LINE_WORDS[11:0] - 12'd1) ? 12'h000 : ocnt_r + 1'b1;
            end
        end
    end
endmodule

// [bench/erlf_reg_src.sv]
/* register source model for the embedded line framer.
   assumes reads are single-cycle pulses; data is due one cycle later. */
`timescale 1ns/100ps
module erlf_reg_src (
    input  logic        i_ref_clk,
    input  logic [15:0] i_reg_addr,
    input  logic        i_reg_rd,
    input  logic [7:0]  i_salt,
    output logic [7:0]  o_reg_data = 8'h00
);
    // ----------
    // read port
    // ----------
    always @(posedge i_ref_clk) begin
        if (i_reg_rd) begin
            case (i_reg_addr)
                16'h0009: o_reg_data <= 8'h2a;
                16'h0087: o_reg_data <= 8'h7f;
                16'h0407: o_reg_data <= 8'h10;
                default:  o_reg_data <= i_reg_addr[7:0] ^ i_reg_addr[15:8] ^ i_salt;
            endcase
        end else begin
            // stale byte toggles so a late sample is caught
            o_reg_data <= ~o_reg_data;
        end
    end
endmodule

// [bench/erlf_framer_props.sv]
/* concurrent checks on the embedded line framer ports.
   assumes one clock and a synchronous active-low reset. */
`timescale 1ns/100ps
module erlf_framer_chk #(
    parameter int LINE_WORDS = 256
) (
    input logic       i_ref_clk,
    input logic       i_nrst,
    input logic       i_frame_start,
    input logic       i_serial_path,
    input logic [2:0] i_parallel_output_source_select,
    input logic       i_raw10,
    input logic       i_out_ready,
    input logic [9:0] o_data,
    input logic       o_valid,
    input logic       o_line_start,
    input logic       o_line_end,
    input logic       o_busy
);
    logic        mode_r;
    logic        row_r;
    logic [11:0] cnt_r;
    wire         en_w = i_serial_path || (i_parallel_output_source_select == 3'h2);
    wire         take_w = i_frame_start && !o_busy && en_w;
    wire  [7:0]  dbyte_w = mode_r ? o_data[9:2] : o_data[7:0];
    // ----------
    // helpers
    // ----------
    always @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            mode_r <= 1'b0;
            row_r <= 1'b0;
            cnt_r <= 12'h000;
        end else begin
            if (take_w) mode_r <= i_raw10;
            if (take_w) row_r <= 1'b0;
            else if (o_valid && i_out_ready && o_line_end) row_r <= ~row_r;
            if (o_valid && i_out_ready) cnt_r <= o_line_end ? 12'h000 : cnt_r + 12'h001;
        end
    end
    // ----------
    // properties
    // ----------
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    sequence s_opened;
        o_valid && o_line_start;
    endsequence
    raw10_lsb_a: assert property (o_valid && mode_r |-> o_data[1:0] == 2'b01)
        else $error("raw10 low bits wrong");
    raw8_top_a: assert property (o_valid && !mode_r |-> o_data[9:8] == 2'b00)
        else $error("raw8 top bits set");
    fmt_open_a: assert property (s_opened |-> dbyte_w == 8'h0a && cnt_r == 0)
        else $error("line does not open with format code");
    null_tail_a: assert property (o_valid && o_line_end |-> dbyte_w == 8'h07)
        else $error("line does not end with null code");
    line_len_a: assert property (o_valid && o_line_end |-> cnt_r == LINE_WORDS - 1)
        else $error("line length wrong");
    start_busy_a: assert property (take_w |=> o_busy)
        else $error("accepted start did not set busy");
    start_open_a: assert property (take_w |-> ##[1:8] s_opened)
        else $error("first row not opened in time");
    refuse_off_a: assert property (i_frame_start && !o_busy && !en_w |=> !o_busy)
        else $error("start taken while disabled");
    word_hold_a: assert property (o_valid && !i_out_ready |=> o_valid && $stable(o_data))
        else $error("word changed while stalled");
    idx_hi_a: assert property (o_valid && cnt_r == 12'd1 |-> dbyte_w == 8'haa)
        else $error("index high tag missing");
    row_base_a: assert property (o_valid && cnt_r == 12'd2 |->
        dbyte_w == (row_r ? 8'h02 : 8'h00))
        else $error("row start address high byte wrong");
    idx_lo_a: assert property (o_valid && cnt_r == 12'd3 |-> dbyte_w == 8'ha5)
        else $error("index low tag missing");
    lo_base_a: assert property (o_valid && cnt_r == 12'd4 |-> dbyte_w == 8'h00)
        else $error("row start address low byte wrong");
    first_tag_a: assert property (o_valid && cnt_r == 12'd5 |-> dbyte_w == 8'h5a)
        else $error("auto-increment tag missing");
endmodule
bind erlf_framer erlf_framer_chk #(.LINE_WORDS(LINE_WORDS)) u_chk (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_frame_start(i_frame_start),
    .i_serial_path(i_serial_path), .i_raw10(i_raw10), .i_out_ready(i_out_ready),
    .i_parallel_output_source_select(i_parallel_output_source_select),
    .o_data(o_data), .o_valid(o_valid), .o_line_start(o_line_start),
    .o_line_end(o_line_end), .o_busy(o_busy)
);

// [bench/tb_top.sv]
/* self-checking bench for the embedded line framer.
   assumes the register source model answers one cycle after a read. */
`timescale 1ns/100ps
module tb_top;
    localparam int LW = 256;
    logic        i_ref_clk = 1'b0;
    logic        i_nrst = 1'b0;
    logic        i_frame_start = 1'b0;
    logic        i_serial_path = 1'b0;
    logic [2:0]  i_parallel_output_source_select = 3'h0;
    logic        i_raw10 = 1'b0;
    logic        i_out_ready = 1'b0;
    logic        stall = 1'b1;
    logic [7:0]  salt = 8'h00;
    wire  [7:0]  i_reg_data;
    wire  [15:0] o_reg_addr;
    wire         o_reg_rd, o_valid, o_line_start, o_line_end, o_busy;
    wire  [9:0]  o_data;
    logic [9:0]  exp_q[$];
    logic [9:0]  e;
    logic [15:0] rs[16] = '{16'h0000, 16'h0010, 16'h0040, 16'h0080, 16'h0084, 16'h00c0,
        16'h0100, 16'h0110, 16'h0120, 16'h0200, 16'h0300, 16'h0340, 16'h0380, 16'h0400,
        16'h0500, 16'h0600};
    int          rc[16] = '{10, 16, 32, 2, 16, 16, 6, 4, 2, 22, 12, 16, 8, 8, 2, 18};
    int          n_mismatch = 0;
    int          total_checks = 0;
    int          widx = 0;
    erlf_framer #(.LINE_WORDS(LW)) DUT (
        .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_frame_start(i_frame_start),
        .i_serial_path(i_serial_path), .i_raw10(i_raw10), .i_reg_data(i_reg_data),
        .i_parallel_output_source_select(i_parallel_output_source_select),
        .i_out_ready(i_out_ready), .o_reg_addr(o_reg_addr), .o_reg_rd(o_reg_rd),
        .o_data(o_data), .o_valid(o_valid), .o_line_start(o_line_start),
        .o_line_end(o_line_end), .o_busy(o_busy)
    );
    erlf_reg_src u_src (
        .i_ref_clk(i_ref_clk), .i_reg_addr(o_reg_addr), .i_reg_rd(o_reg_rd),
        .i_salt(salt), .o_reg_data(i_reg_data)
    );
    // ----------
    // tasks
    // ----------
    function automatic logic [7:0] reg_val(input logic [15:0] a);
        if (a == 16'h0009) return 8'h2a;
        if (a == 16'h0087) return 8'h7f;
        if (a == 16'h0407) return 8'h10;
        return a[7:0] ^ a[15:8] ^ salt;
    endfunction
    task automatic push(input logic [7:0] b);
        exp_q.push_back(i_raw10 ? {b, 2'b01} : {2'b00, b});
    endtask
    task automatic push_row(input int lo, input int hi);
        int n;
        n = 1;
        push(8'h0a);
        for (int k = lo; k < hi; k++) begin
            push(8'haa);
            push(rs[k][15:8]);
            push(8'ha5);
            push(rs[k][7:0]);
            n += 4;
            for (int j = 0; j < rc[k]; j++) begin
                push(8'h5a);
                push(reg_val(rs[k] + 16'(j)));
                n += 2;
            end
        end
        while (n < LW) begin
            push(8'h07);
            n++;
        end
    endtask
    task automatic check(input string nm, input logic [9:0] ex, input logic [9:0] got);
        total_checks++;
        if (got !== ex) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic run_frame(input logic ser, input logic [2:0] sel, input logic raw);
        logic on;
        int   w;
        @(negedge i_ref_clk);
        on = ser || (sel == 3'h2);
        salt = 8'($urandom);
        i_serial_path = ser;
        i_parallel_output_source_select = sel;
        i_raw10 = raw;
        if (on) push_row(0, 9);
        if (on) push_row(9, 16);
        i_frame_start = 1'b1;
        @(negedge i_ref_clk);
        i_frame_start = 1'b0;
        @(negedge i_ref_clk);
        check("busy", {9'h0, on}, {9'h0, o_busy});
        // a second start while busy must be dropped
        i_frame_start = 1'b1;
        @(negedge i_ref_clk);
        i_frame_start = 1'b0;
        w = 0;
        while ((o_busy || exp_q.size() != 0) && w < 20000) begin
            @(negedge i_ref_clk);
            w++;
        end
        if (w >= 20000) n_mismatch++;
    endtask
    // ----------
    // stimulus and monitor
    // ----------
    initial forever #10 i_ref_clk = ~i_ref_clk;
    always @(negedge i_ref_clk) i_out_ready <= !stall && ($urandom % 4 != 0);
    initial #8005 stall = 1'b0;
    initial begin
        #(60000 * 20);
        n_mismatch++;
        report_and_stop();
    end
    always @(posedge i_ref_clk) begin
        if (i_nrst && o_valid === 1'b1 && i_out_ready) begin
            e = (exp_q.size() != 0) ? exp_q.pop_front() : 10'h3ff;
            check("word", e, o_data);
            check("line_start", {9'h0, widx == 0}, {9'h0, o_line_start});
            check("line_end", {9'h0, widx == LW - 1}, {9'h0, o_line_end});
            widx = (widx == LW - 1) ? 0 : widx + 1;
        end
    end
    initial begin
        void'($urandom(38136));
        repeat (5) @(negedge i_ref_clk);
        i_nrst = 1'b1;
        run_frame(1'b1, 3'h0, 1'b1);
        run_frame(1'b1, 3'h5, 1'b0);
        for (int s = 0; s < 8; s++) run_frame(1'b0, 3'(s), s[0]);
        report_and_stop();
    end
endmodule
